// ---- verilog/frwc_pkg.sv ----
// frwc_pkg: register map, field layout, reset values and timing for the frame readout window control
// assumes a 50 MHz aclk and an AXI4-Lite master with 32-bit data
package frwc_pkg;
    localparam int          DIM_W          = 11;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_OFFSET    = 8'h04;
    localparam logic [7:0]  ADDR_SIZE      = 8'h08;
    localparam logic [7:0]  ADDR_EXPTIME   = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;
    // ctrl fields
    localparam int          C_DELAYED      = 0;
    localparam int          C_TRIG_ON      = 1;
    localparam int          C_MODE_LSB     = 2;
    localparam int          C_HBIN         = 5;
    localparam int          C_VBIN         = 6;
    localparam int          C_SEQ_ROI      = 7;
    localparam int          C_MULTI_ROI    = 8;
    localparam int          C_OVERLAP      = 9;
    localparam int          C_ALC          = 10;
    localparam int          C_AUTO_GS      = 11;
    localparam int          C_TOP          = 11;
    localparam int          HI_LSB         = 16;
    // status fields
    localparam int          S_WAITING      = 0;
    localparam int          S_SENDING      = 1;
    localparam int          S_EXP_REJ      = 2;
    localparam int          S_EFF_LSB      = 3;
    // exposure mode codes
    localparam logic [2:0]  MODE_OFF       = 3'h0;
    localparam logic [2:0]  MODE_TIMED     = 3'h1;
    localparam logic [2:0]  MODE_WIDTH     = 3'h2;
    localparam logic [2:0]  MODE_PREDUMP   = 3'h3;
    localparam logic [2:0]  MODE_DUAL      = 3'h4;
    // frame geometry
    localparam logic [DIM_W-1:0] FULL_COLS = 11'd1632;
    localparam logic [DIM_W-1:0] FULL_LINES = 11'd1204;
    localparam logic [DIM_W-1:0] HBIN_COLS = 11'd616;
    localparam logic [DIM_W-1:0] VBIN_LINES = 11'd604;
    localparam logic [DIM_W-1:0] RST_OX    = 11'd16;
    localparam logic [DIM_W-1:0] RST_OY    = 11'd4;
    localparam logic [DIM_W-1:0] RST_W     = 11'd1600;
    localparam logic [DIM_W-1:0] RST_H     = 11'd1200;
    localparam logic [19:0] RST_EXPTIME    = 20'h0_0064;
    // exposure time unit
    localparam int          CLK_NS         = 20;
    localparam int          EXP_UNIT_NS    = 1000;
    localparam int          UNIT_CYCLES    = EXP_UNIT_NS / CLK_NS;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    typedef enum logic [3:0] {
        FRWC_IDLE   = 4'b0001,
        FRWC_EXPOSE = 4'b0010,
        FRWC_HOLD   = 4'b0100,
        FRWC_SEND   = 4'b1000
    } frwc_state_t;
endpackage

// ---- verilog/frwc_scan.sv ----
// frwc_scan: walks one sensor frame line by line, one column per cycle, and marks the pixels inside the readout window
// assumes geometry inputs stay stable while a scan runs
module frwc_scan
    import frwc_pkg::*;
#(
    parameter int W = DIM_W
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         start,
    input  wire logic [W-1:0] cols,
    input  wire logic [W-1:0] lines,
    input  wire logic [W-1:0] ox,
    input  wire logic [W-1:0] oy,
    input  wire logic [W-1:0] wid,
    input  wire logic [W-1:0] hgt,
    output logic              active,
    output logic              keep,
    output logic              sof,
    output logic              eol,
    output logic              done,
    output logic [W-1:0]      col,
    output logic [W-1:0]      line
);
    logic         last_col;
    logic         last_line;
    logic [W:0]   x_end;
    logic [W:0]   y_end;
    logic         in_win;

    assign last_col  = (col == cols - 1'b1);
    assign last_line = (line == lines - 1'b1);
    assign x_end     = {1'b0, ox} + {1'b0, wid};
    assign y_end     = {1'b0, oy} + {1'b0, hgt};
    assign in_win    = (col >= ox) && ({1'b0, col} < x_end) && (line >= oy) && ({1'b0, line} < y_end);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active <= 1'b0;
            col    <= '0;
            line   <= '0;
        end
        else if (start && !active)
        begin
            active <= 1'b1;
            col    <= '0;
            line   <= '0;
        end
        else if (active)
        begin
            if (last_col)
            begin
                col  <= '0;
                line <= line + 1'b1;
                if (last_line)
                    active <= 1'b0;
            end
            else
                col <= col + 1'b1;
        end
    end

    // keep and the frame marks describe the pixel that is current this cycle
    always_comb
    begin
        keep = active && in_win;
        sof  = active && (col == ox) && (line == oy);
        eol  = active && in_win && ({1'b0, col} == x_end - 1'b1);
        done = active && last_col && last_line;
    end
endmodule

// ---- verilog/frwc_top.sv ----
// frwc_top: frame capture, delayed network release and readout window control behind an AXI4-Lite slave
// assumes triggers are synchronous to aclk; the pixel stream feeds the network packetiser downstream
module frwc_top
    import frwc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              frame_start_trigger,
    input  wire logic              transfer_release_trigger,
    output logic                   exposing,
    output logic                   pix_valid,
    output logic                   pix_sof,
    output logic                   pix_eol,
    output logic [DIM_W-1:0]       pix_col,
    output logic [DIM_W-1:0]       pix_line
);
    logic [C_TOP:0]     ctrl;
    logic [DIM_W-1:0]   ox, oy, wid, hgt;
    logic [19:0]        exp_time;
    logic               exp_rej;
    logic [7:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               aw_held, w_held;
    logic               do_write;
    logic               fs_d, tr_d;
    logic               fs_rise, tr_rise;
    frwc_state_t        state;
    logic [19:0]        exp_cnt;
    logic [7:0]         unit_cnt;
    logic               unit_tick;
    logic               scan_start;
    logic               sc_active, sc_keep, sc_sof, sc_eol, sc_done;
    logic [DIM_W-1:0]   sc_col, sc_line;
    logic [2:0]         mode;
    logic               trig_on, timed;
    logic               ok_seq, ok_multi, ok_ovl, ok_alc, ok_vbin, ok_auto, exp_locked;
    logic [5:0]         eff;
    logic [31:0]        rd_word;
    logic               rd_hit;

    assign mode       = ctrl[C_MODE_LSB +: 3];
    assign trig_on    = ctrl[C_TRIG_ON];
    assign timed      = (mode == MODE_TIMED);
    // mode and function matrix
    assign ok_seq     = timed && trig_on;
    assign ok_multi   = trig_on && (timed || mode == MODE_WIDTH || mode == MODE_PREDUMP);
    assign ok_ovl     = trig_on && (timed || mode == MODE_WIDTH);
    assign ok_alc     = !trig_on || mode == MODE_PREDUMP;
    assign ok_vbin    = (mode != MODE_PREDUMP) && (mode != MODE_DUAL);
    assign ok_auto    = (timed && !trig_on) || mode == MODE_PREDUMP;
    assign exp_locked = (mode == MODE_WIDTH) || (mode == MODE_OFF);
    assign eff = {ctrl[C_AUTO_GS] & ok_auto, ctrl[C_ALC] & ok_alc, ctrl[C_OVERLAP] & ok_ovl,
                  ctrl[C_MULTI_ROI] & ok_multi, ctrl[C_SEQ_ROI] & ok_seq, ctrl[C_VBIN] & ok_vbin};

    // ---------------- bus write side ----------------
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == ADDR_CTRL || aw_addr == ADDR_OFFSET || aw_addr == ADDR_SIZE
                || aw_addr == ADDR_EXPTIME || aw_addr == ADDR_STATUS)
                s_axi_bresp <= RESP_OKAY;
            else
                s_axi_bresp <= RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // registers; byte lanes honoured per strobe except exposure time, written whole; window fields sit in the low and high halves
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl     <= '0;
            ox       <= RST_OX;
            oy       <= RST_OY;
            wid      <= RST_W;
            hgt      <= RST_H;
            exp_time <= RST_EXPTIME;
        end
        else if (do_write)
        begin
            if (aw_addr == ADDR_CTRL)
            begin
                if (w_strb[0])
                    ctrl[7:0] <= w_data[7:0];
                if (w_strb[1])
                    ctrl[C_TOP:8] <= w_data[C_TOP:8];
            end
            else if (aw_addr == ADDR_OFFSET)
            begin
                if (w_strb[0]) ox[7:0] <= w_data[7:0];
                if (w_strb[1]) ox[DIM_W-1:8] <= w_data[DIM_W-1:8];
                if (w_strb[2]) oy[7:0] <= w_data[HI_LSB +: 8];
                if (w_strb[3]) oy[DIM_W-1:8] <= w_data[HI_LSB+8 +: DIM_W-8];
            end
            else if (aw_addr == ADDR_SIZE)
            begin
                if (w_strb[0]) wid[7:0] <= w_data[7:0];
                if (w_strb[1]) wid[DIM_W-1:8] <= w_data[DIM_W-1:8];
                if (w_strb[2]) hgt[7:0] <= w_data[HI_LSB +: 8];
                if (w_strb[3]) hgt[DIM_W-1:8] <= w_data[HI_LSB+8 +: DIM_W-8];
            end
            else if (aw_addr == ADDR_EXPTIME && !exp_locked)
                exp_time <= w_data[19:0];
        end
    end

    // sticky reject flag; a fresh reject beats a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            exp_rej <= 1'b0;
        else if (do_write && aw_addr == ADDR_EXPTIME && exp_locked)
            exp_rej <= 1'b1;
        else if (do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[S_EXP_REJ])
            exp_rej <= 1'b0;
    end

    // ---------------- bus read side ----------------
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == ADDR_CTRL)
            rd_word[C_TOP:0] = ctrl;
        else if (s_axi_araddr == ADDR_OFFSET)
            rd_word = {5'h00, oy, 5'h00, ox};
        else if (s_axi_araddr == ADDR_SIZE)
            rd_word = {5'h00, hgt, 5'h00, wid};
        else if (s_axi_araddr == ADDR_EXPTIME)
            rd_word[19:0] = exp_time;
        else if (s_axi_araddr == ADDR_STATUS)
        begin
            rd_word[S_WAITING] = (state == FRWC_HOLD);
            rd_word[S_SENDING] = (state == FRWC_SEND);
            rd_word[S_EXP_REJ] = exp_rej;
            rd_word[S_EFF_LSB +: 6] = eff;
        end
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- capture and release ----------------
    assign fs_rise   = frame_start_trigger && !fs_d;
    assign tr_rise   = transfer_release_trigger && !tr_d;
    assign unit_tick = (unit_cnt == 8'(UNIT_CYCLES - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fs_d <= 1'b0;
            tr_d <= 1'b0;
        end
        else
        begin
            fs_d <= frame_start_trigger;
            tr_d <= transfer_release_trigger;
        end
    end

    // microsecond enable for timed exposure, counting only in the expose state
    always_ff @(posedge aclk)
    begin
        if (!aresetn || unit_tick || state != FRWC_EXPOSE)
            unit_cnt <= 8'h00;
        else
            unit_cnt <= unit_cnt + 1'b1;
    end

    // untriggered operation restarts a frame as soon as the last one has gone
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state   <= FRWC_IDLE;
            exp_cnt <= 20'h0_0000;
        end
        else
        begin
            case (state)
                FRWC_IDLE:
                    if (trig_on ? fs_rise : 1'b1)
                    begin
                        state   <= FRWC_EXPOSE;
                        exp_cnt <= exp_time;
                    end
                FRWC_EXPOSE:
                    if (mode == MODE_WIDTH ? !frame_start_trigger
                        : (mode == MODE_OFF || exp_cnt == 20'h0_0000))
                        state <= ctrl[C_DELAYED] ? FRWC_HOLD : FRWC_SEND;
                    else if (unit_tick && mode != MODE_WIDTH)
                        exp_cnt <= exp_cnt - 1'b1;
                FRWC_HOLD:
                    if (tr_rise)
                        state <= FRWC_SEND;
                FRWC_SEND:
                    if (sc_done)
                        state <= FRWC_IDLE;
                default:
                    state <= FRWC_IDLE;
            endcase
        end
    end
    // a release edge outside the hold state falls through the case above unused

    assign scan_start = (state == FRWC_SEND) && !sc_active && !sc_done;

    frwc_scan #(
        .W      (DIM_W)
    ) u_scan (
        .aclk   (aclk),
        .aresetn(aresetn),
        .start  (scan_start),
        .cols   (ctrl[C_HBIN] ? HBIN_COLS : FULL_COLS),
        .lines  (eff[0] ? VBIN_LINES : FULL_LINES),
        .ox     (ox),
        .oy     (oy),
        .wid    (wid),
        .hgt    (hgt),
        .active (sc_active),
        .keep   (sc_keep),
        .sof    (sc_sof),
        .eol    (sc_eol),
        .done   (sc_done),
        .col    (sc_col),
        .line   (sc_line)
    );

    // registered network-side stream; pixels outside the window never leave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            exposing  <= 1'b0;
            pix_valid <= 1'b0;
            pix_sof   <= 1'b0;
            pix_eol   <= 1'b0;
            pix_col   <= '0;
            pix_line  <= '0;
        end
        else
        begin
            exposing  <= (state == FRWC_EXPOSE);
            pix_valid <= sc_keep;
            pix_sof   <= sc_sof;
            pix_eol   <= sc_eol;
            pix_col   <= sc_col;
            pix_line  <= sc_line;
        end
    end
endmodule

// ---- dv/frwc_assertions.sv ----
// frwc_assertions: port-level checks of the bus and pixel stream of frwc_top
// assumes one aclk domain and the synchronous active-low aresetn
module frwc_assertions
    import frwc_pkg::*;
(
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [7:0]       s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [7:0]       s_axi_araddr,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic             exposing,
    input wire logic             pix_valid,
    input wire logic             pix_sof,
    input wire logic             pix_eol,
    input wire logic [DIM_W-1:0] pix_col,
    input wire logic [DIM_W-1:0] pix_line
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // a frame opens on a fresh window pixel, never mid-run
    property p_sof; pix_sof |-> pix_valid && !$past(pix_valid); endproperty
    a_sof: assert property (p_sof) else $error("frame start off window");
    // only a row wrap may keep the window open after a line end
    property p_eol; pix_eol |-> pix_valid ##1 (!pix_valid || pix_col == 11'd0); endproperty
    a_eol: assert property (p_eol) else $error("line end off window");
    property p_step; pix_valid && $past(pix_valid) && !$past(pix_eol) |-> pix_col == $past(pix_col) + 11'd1; endproperty
    a_step: assert property (p_step) else $error("window pixels not adjacent");
    property p_range; pix_valid |-> pix_col < FULL_COLS && pix_line < FULL_LINES; endproperty
    a_range: assert property (p_range) else $error("pixel outside sensor frame");
    property p_expo; exposing |-> !pix_valid; endproperty
    a_expo: assert property (p_expo) else $error("pixels during exposure");
    property p_awp; s_axi_awready |=> !s_axi_awready; endproperty
    a_awp: assert property (p_awp) else $error("awready longer than a pulse");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rbad; s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STATUS
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
    a_rbad: assert property (p_rbad) else $error("unmapped read not refused");
    property p_wbad; s_axi_awvalid && s_axi_awready && s_axi_awaddr > ADDR_STATUS
        |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR); endproperty
    a_wbad: assert property (p_wbad) else $error("unmapped write not refused");

    c_sof: cover property (pix_sof);
    c_eol: cover property (pix_eol);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind frwc_top frwc_assertions frwc_assertions_i (.*);

// ---- dv/frwc_host_model.sv ----
// frwc_host_model: network-side receiver that records the first window line of a frame
// assumes the pixel stream of frwc_top on the same aclk
module frwc_host_model
    import frwc_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             pix_valid,
    input  wire logic             pix_sof,
    input  wire logic             pix_eol,
    input  wire logic [DIM_W-1:0] pix_col,
    input  wire logic [DIM_W-1:0] pix_line,
    output logic      [DIM_W-1:0] sof_col,
    output logic      [DIM_W-1:0] sof_line,
    output logic      [DIM_W-1:0] eol_col,
    output logic      [15:0]      line_len,
    output logic                  got_sof,
    output logic                  got_eol
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the first line is kept: a whole frame is far too long to simulate
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            got_sof  <= 1'b0;
            got_eol  <= 1'b0;
            line_len <= 16'h0000;
        end
        else if (pix_valid && pix_sof && !got_sof)
        begin
            got_sof  <= 1'b1;
            sof_col  <= pix_col;
            sof_line <= pix_line;
            line_len <= 16'h0001;
            got_eol  <= pix_eol;
            eol_col  <= pix_col;
        end
        else if (pix_valid && got_sof && !got_eol)
        begin
            line_len <= line_len + 16'h0001;
            got_eol  <= pix_eol;
            eol_col  <= pix_col;
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// tb_top: register, mode matrix and readout window tests for frwc_top
// assumes the host model on the pixel stream and the checker bound to the top
module tb_top
    import frwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]      s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0]       s_axi_wstrb = 4'hF;
    logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic             s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]       s_axi_bresp, s_axi_rresp, rsp;
    logic             frame_start_trigger = 1'b0, transfer_release_trigger = 1'b0;
    logic             exposing, pix_valid, pix_sof, pix_eol, got_sof, got_eol;
    logic [DIM_W-1:0] pix_col, pix_line, sof_col, sof_line, eol_col;
    logic [15:0]      line_len;
    int               miscompares = 0, comparisons = 0, cyc = 0;
    // requested features against the ones the mode allows, status [8:3]
    logic [31:0]      mctl [7] = '{32'h0000_0FC0, 32'h0000_0FC4, 32'h0000_0FC6, 32'h0000_0FCA,
                                   32'h0000_0F8E, 32'h0000_004E, 32'h0000_0FD2};
    logic [5:0]       meff [7] = '{6'h11, 6'h31, 6'h0F, 6'h0D, 6'h34, 6'h00, 6'h00};
    logic [2:0]       emode [3] = '{MODE_OFF, MODE_WIDTH, MODE_TIMED};
    logic [31:0]      woff [4] = '{32'h0000_0010, 32'h0004_0000, 32'h0004_0000, 32'h0004_0008};
    logic [31:0]      wsiz [4] = '{32'h04B4_0640, 32'h04B0_0660, 32'h04B0_0650, 32'h04B0_0640};

    frwc_top frwc_top_i (.*);
    frwc_host_model frwc_host_model_i (.*);

    always #10 aclk = ~aclk;

    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address and data are offered together and dropped one by one as taken
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        // bready waits for bvalid so the slave has to hold its response for a cycle
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        // one stalled cycle so the slave has to hold its read data
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(rd & m, e);
        chk({30'h0, rsp}, {30'h0, er});
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            miscompares++;
            end_sim();
        end
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdm(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY);
        rdm(ADDR_OFFSET, 32'hFFFF_FFFF, 32'h0004_0010, RESP_OKAY);
        rdm(ADDR_SIZE, 32'hFFFF_FFFF, 32'h04B0_0640, RESP_OKAY);
        rdm(ADDR_EXPTIME, 32'hFFFF_FFFF, 32'h0000_0064, RESP_OKAY);
        rdm(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
        wrc(8'h44, 32'h0000_1234, RESP_SLVERR);
        while (got_eol !== 1'b1) @(posedge aclk);
        chk({21'h0, sof_col}, 32'h0000_0010);
        chk({21'h0, sof_line}, 32'h0000_0004);
        chk({21'h0, eol_col}, 32'h0000_064F);
        chk({16'h0, line_len}, 32'h0000_0640);
        for (int i = 0; i < 7; i++)
        begin
            wrc(ADDR_CTRL, mctl[i], RESP_OKAY);
            rdm(ADDR_CTRL, 32'h0000_0FFF, mctl[i], RESP_OKAY);
            rdm(ADDR_STATUS, 32'h0000_01F8, {23'h0, meff[i], 3'h0}, RESP_OKAY);
        end
        // triggers land while a frame is still streaming, nothing is waiting
        wrc(ADDR_CTRL, 32'h0000_0007, RESP_OKAY);
        @(posedge aclk);
        frame_start_trigger <= 1'b1;
        transfer_release_trigger <= 1'b1;
        repeat (2) @(posedge aclk);
        frame_start_trigger <= 1'b0;
        transfer_release_trigger <= 1'b0;
        rdm(ADDR_STATUS, 32'h0000_0003, 32'h0000_0002, RESP_OKAY);
        for (int i = 0; i < 3; i++)
        begin
            wrc(ADDR_CTRL, {27'h0, emode[i], 2'b00}, RESP_OKAY);
            wrc(ADDR_STATUS, 32'h0000_0004, RESP_OKAY);
            wrc(ADDR_EXPTIME, 32'h0000_0005, RESP_OKAY);
            rdm(ADDR_EXPTIME, 32'h000F_FFFF, (i < 2) ? 32'h0000_0064 : 32'h0000_0005, RESP_OKAY);
            rdm(ADDR_STATUS, 32'h0000_0004, (i < 2) ? 32'h0000_0004 : 32'h0000_0000, RESP_OKAY);
        end
        for (int i = 0; i < 4; i++)
        begin
            wrc(ADDR_OFFSET, woff[i], RESP_OKAY);
            wrc(ADDR_SIZE, wsiz[i], RESP_OKAY);
            rdm(ADDR_OFFSET, 32'hFFFF_FFFF, woff[i], RESP_OKAY);
            rdm(ADDR_SIZE, 32'hFFFF_FFFF, wsiz[i], RESP_OKAY);
        end
        // mid-run reset: free-running restart shows a one-cycle exposure two edges after release
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, exposing}, 32'h0000_0001);
        rdm(ADDR_OFFSET, 32'hFFFF_FFFF, 32'h0004_0010, RESP_OKAY);
        end_sim();
    end
endmodule
